// File: dv/rms_chk.sv
/* Port checker for the mode, strap and load block.
   Assumes only the top ports; the role bit is tracked from APB writes. */
`timescale 1ns/1ps
module rms_chk #(
  parameter int LOAD_CLOCKS = rms_pkg::LOAD_SCL_CLOCKS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic scl_oe_n,
  input wire logic id_strap1_load_done_n_oe_n,
  input wire logic lock_pin_out,
  input wire logic lock_pin_oe_n,
  input wire logic signal_detect_irq_pin_oe_n,
  input wire logic chan_a_locked,
  input wire logic chan_b_locked,
  input wire logic chan_a_signal_present,
  input wire logic [1:0] config_mode,
  input wire logic [6:0] smbus_addr,
  input wire logic pin_rate_limited,
  input wire logic load_busy
);
  logic [5:0] cnt;
  logic [8:0] pc;
  logic irq_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  always_ff @(posedge clock) begin
    if (!rstn) cnt <= 6'h00;
    else if (cnt != 6'h3F) cnt <= cnt + 6'h01;
  end
  always_ff @(posedge clock) begin
    if (!rstn) irq_q <= 1'b0;
    else if (psel && penable && pwrite && paddr == 12'h000) irq_q <= pwdata[0];
  end
  // Clock low pulses driven during a load
  always_ff @(posedge clock) begin
    if (!rstn) pc <= 9'h000;
    else if ($fell(scl_oe_n)) pc <= pc + 9'h001;
  end
  lock_follow_a: assert property (
    $past(rstn) |-> lock_pin_out == $past(chan_a_locked && chan_b_locked))
    else $error("lock pin not both locks");
  strap_first_a: assert property (cnt < 6'h14 |-> lock_pin_oe_n)
    else $error("lock pin driven during strap sampling");
  lock_drive_a: assert property (cnt == 6'h28 |-> !lock_pin_oe_n)
    else $error("lock pin not driven after startup");
  sd_present_a: assert property (
    !irq_q |=> signal_detect_irq_pin_oe_n == !$past(chan_a_signal_present))
    else $error("signal detect not following input");
  mode_hold_a: assert property (
    cnt > 6'h28 |-> $stable(config_mode) && $stable(smbus_addr))
    else $error("decoded straps changed");
  rate_limit_a: assert property (
    cnt > 6'h28 |-> pin_rate_limited == (config_mode == rms_pkg::MODE_PIN))
    else $error("rate limit flag wrong");
  clk_busy_a: assert property (!load_busy |-> scl_oe_n)
    else $error("bus clock pulled outside load");
  low_width_a: assert property ($fell(scl_oe_n) |-> !scl_oe_n [*8])
    else $error("bus clock low phase too short");
  done_count_a: assert property (
    $fell(id_strap1_load_done_n_oe_n) |-> pc == LOAD_CLOCKS)
    else $error("done before all clocks");
  done_hold_a: assert property (
    !id_strap1_load_done_n_oe_n |=> !id_strap1_load_done_n_oe_n)
    else $error("done released");
  bus_error_a: assert property (
    psel && penable |-> pslverr == (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0))
    else $error("slave error wrong");
  cover property ($fell(id_strap1_load_done_n_oe_n));
  cover property (psel && penable && pslverr);
  cover property (irq_q && !signal_detect_irq_pin_oe_n);
endmodule : rms_chk

bind rms_mode_strap rms_chk #(.LOAD_CLOCKS(LOAD_CLOCKS)) i_rms_chk (.*);

// File: dv/rms_host_model.sv
/* Far side of the load handshake: bus clock wire and upstream done.
   Assumes the device pulls the clock low through an active-low enable. */
`timescale 1ns/1ps
module rms_host_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic upstream_done_n,
  input wire logic stall,
  input wire logic scl_oe_n,
  output logic scl_level,
  output logic [1:0] req_code,
  output logic [7:0] pulses
);
  logic prev;
  // open-drain clock wire
  // Pull-up level unless pulled; stall stretches a high phase
  assign scl_level = scl_oe_n && !stall;
  assign req_code = upstream_done_n ? rms_pkg::LVL_HIGH : rms_pkg::LVL_LOW;
  always_ff @(posedge clock) begin
    prev <= scl_level;
    if (!rstn) pulses <= 8'h00;
    // A stall pulls the wire low too; only the device's pulls count
    else if (prev && !scl_level && !stall) pulses <= pulses + 8'h01;
  end
endmodule : rms_host_model

// File: dv/tb_top.sv
/* Self-checking bench for the mode, strap and load block.
   Assumes the host model on the bus clock and a 20 MHz clock. */
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [1:0] mp, dr, id, m, rt;
    logic ls, ea, eb;
    logic [6:0] ad;
  } rms_row_s;
  localparam int LP = 4;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, scl_in, scl_oe_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] bus_mode_select_pin, sda_deemph_a_code, scl_deemph_b_code, disable_route_code;
  logic [1:0] load_req_swing_a_code, id1_swing_b_code, lr, p_req, config_mode, route_sel;
  logic [1:0] chan_a_deemph, chan_b_deemph, chan_a_swing, chan_b_swing;
  logic id_strap1_load_done_n_oe_n, lock_pin_in, lock_pin_out, lock_pin_oe_n;
  logic signal_detect_irq_pin_oe_n, chan_a_locked, chan_b_locked, chan_a_signal_present;
  logic eye_check_done, use_p, upstream_done_n, stall, err;
  logic port_a_output_en, port_b_output_en, pin_rate_limited, load_busy;
  logic [7:0] eye_horiz, eye_vert, pulses;
  logic [6:0] smbus_addr;
  int fail_count, check_count;
  logic [11:0] ra [3] = '{12'h000, 12'h004, 12'h008};
  logic [31:0] rv [3] = '{rms_pkg::CTRL_RESET, rms_pkg::THRESH_RESET, rms_pkg::DRIVE_RESET};
  rms_row_s rows [8] = '{
    '{2'h2, 2'h2, 2'h2, 2'h0, 2'h0, 1'b1, 1'b1, 1'b0, 7'h33},
    '{2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0, 1'b1, 1'b1, 7'h30},
    '{2'h2, 2'h3, 2'h1, 2'h0, 2'h0, 1'b1, 1'b1, 1'b1, 7'h31},
    '{2'h2, 2'h1, 2'h3, 2'h0, 2'h0, 1'b0, 1'b1, 1'b1, 7'h30},
    '{2'h0, 2'h2, 2'h2, 2'h2, 2'h0, 1'b0, 1'b1, 1'b1, 7'h00},
    '{2'h0, 2'h3, 2'h2, 2'h2, 2'h1, 1'b0, 1'b1, 1'b1, 7'h00},
    '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 1'b0, 1'b1, 1'b1, 7'h00},
    '{2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 1'b0, 1'b1, 1'b1, 7'h00}};
  assign load_req_swing_a_code = use_p ? p_req : lr;
  rms_mode_strap #(.LOAD_CLOCKS(LP)) i_rms_mode_strap (
    .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .bus_mode_select_pin, .sda_deemph_a_code, .scl_deemph_b_code, .disable_route_code,
    .load_req_swing_a_code, .id1_swing_b_code, .scl_in, .scl_out(), .scl_oe_n,
    .id_strap1_load_done_n_out(), .id_strap1_load_done_n_oe_n, .lock_pin_in, .lock_pin_out,
    .lock_pin_oe_n, .signal_detect_irq_pin_out(), .signal_detect_irq_pin_oe_n,
    .chan_a_locked, .chan_b_locked, .chan_a_signal_present, .eye_check_done, .eye_horiz,
    .eye_vert, .config_mode, .smbus_addr, .route_sel, .port_a_output_en, .port_b_output_en,
    .chan_a_deemph, .chan_b_deemph, .chan_a_swing, .chan_b_swing, .pin_rate_limited,
    .load_busy);
  rms_host_model i_rms_host_model (.clock, .rstn, .upstream_done_n, .stall, .scl_oe_n,
    .scl_level(scl_in), .req_code(p_req), .pulses);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s: %h not %h", $time, m, seen, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic await(ref logic s, input logic v);
    for (int i = 0; s !== v; i++) begin
      if (i == 400) begin
        chk(1'b0, 1'b1, "wait timed out");
        results();
      end
      @(posedge clock);
    end
  endtask : await
  task automatic boot(input logic [1:0] m, r, l, i, input logic s);
    @(posedge clock);
    rstn <= 1'b0;
    bus_mode_select_pin <= m;
    disable_route_code <= r;
    lr <= l;
    id1_swing_b_code <= i;
    lock_pin_in <= s;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (40) @(posedge clock);
  endtask : boot
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    await(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic eye(input logic [7:0] h, v, input logic exp);
    @(posedge clock);
    eye_check_done <= 1'b1;
    eye_horiz <= h;
    eye_vert <= v;
    @(posedge clock);
    eye_check_done <= 1'b0;
    repeat (3) @(posedge clock);
    chk(signal_detect_irq_pin_oe_n, exp, "eye role");
  endtask : eye
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, eye_horiz, eye_vert} = '0;
    {chan_a_locked, chan_b_locked, chan_a_signal_present, eye_check_done, use_p, stall} = '0;
    {bus_mode_select_pin, sda_deemph_a_code, scl_deemph_b_code} = 6'h2A;
    {disable_route_code, lr, id1_swing_b_code, lock_pin_in, upstream_done_n} = 8'hA9;
    fail_count = 0;
    check_count = 0;
    foreach (rows[k]) begin
      // request held low in every row; slave rows ignore it, pin rows read it as swing A
      boot(rows[k].mp, rows[k].dr, 2'h0, rows[k].id, rows[k].ls);
      chk(config_mode, rows[k].m, "mode");
      chk(route_sel, rows[k].rt, "route");
      chk({port_a_output_en, port_b_output_en}, {rows[k].ea, rows[k].eb}, "enables");
      chk(pin_rate_limited, rows[k].m == 2'h2, "rate");
      chk(load_busy, 1'b0, "no load");
      if (rows[k].m == 2'h0) chk(smbus_addr, rows[k].ad, "address");
      if (rows[k].m == 2'h2) chk({chan_b_swing, chan_a_swing, chan_b_deemph, chan_a_deemph}, 8'hCF, "pin drive");
    end
    boot(2'h2, 2'h0, 2'h0, 2'h2, 1'b0);
    // Pads move after startup; decoded straps must not
    bus_mode_select_pin <= 2'h0;
    id1_swing_b_code <= 2'h0;
    foreach (ra[k]) begin
      apb(1'b0, ra[k], 32'h0);
      chk(rd, rv[k], "reset value");
    end
    apb(1'b0, 12'h010, 32'h0);
    chk({err, rd}, 33'h1_0000_0000, "unmapped");
    chk({config_mode, smbus_addr}, 9'h032, "held straps");
    apb(1'b1, 12'h008, 32'h0000_00E4);
    apb(1'b1, 12'h000, 32'h0000_0006);
    repeat (2) @(posedge clock);
    chk({chan_b_swing, chan_a_swing, chan_b_deemph, chan_a_deemph}, 8'hE4, "drive");
    chk(route_sel, 2'h3, "route reg");
    chan_a_signal_present <= 1'b1;
    chan_a_locked <= 1'b1;
    repeat (3) @(posedge clock);
    chk(signal_detect_irq_pin_oe_n, 1'b0, "present");
    chk({lock_pin_oe_n, lock_pin_out}, 2'h0, "one lock");
    chan_a_signal_present <= 1'b0;
    chan_b_locked <= 1'b1;
    repeat (3) @(posedge clock);
    chk(signal_detect_irq_pin_oe_n, 1'b1, "lost");
    chk({lock_pin_oe_n, lock_pin_out}, 2'h1, "both locks");
    apb(1'b1, 12'h000, 32'h0000_0001);
    eye(8'h0F, 8'h20, 1'b0);
    eye(8'h10, 8'h10, 1'b1);
    eye(8'h40, 8'h0F, 1'b0);
    apb(1'b1, 12'h004, 32'h0000_0505);
    eye(8'h05, 8'h05, 1'b1);
    eye(8'h06, 8'h04, 1'b0);
    use_p <= 1'b1;
    boot(2'h3, 2'h0, 2'h2, 2'h2, 1'b0);
    chk({config_mode, load_busy, scl_oe_n, id_strap1_load_done_n_oe_n}, 5'h0B, "idle");
    upstream_done_n <= 1'b0;
    await(scl_oe_n, 1'b0);
    await(scl_oe_n, 1'b1);
    stall <= 1'b1;
    repeat (30) @(posedge clock);
    chk({load_busy, scl_oe_n}, 2'h3, "stretched");
    stall <= 1'b0;
    await(id_strap1_load_done_n_oe_n, 1'b0);
    chk(pulses, LP, "clock pulses");
    upstream_done_n <= 1'b1;
    repeat (5) @(posedge clock);
    upstream_done_n <= 1'b0;
    repeat (30) @(posedge clock);
    chk({load_busy, id_strap1_load_done_n_oe_n, pulses}, 10'h004, "one load");
    results();
  end
endmodule : tb_top

// File: shared/rms_pkg.sv
/*
  Constants, levels and states for the mode, strap and status block of a
  two-channel retimer. Assumes a 20 MHz core clock and APB register access.
*/
package rms_pkg;

  // Four-level pad sense code, as delivered by the analog comparators
  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_R20K = 2'h1,
    LVL_HIGH = 2'h2,
    LVL_FLOAT = 2'h3
  } rms_level_e;

  typedef enum logic [1:0] {
    MODE_SLAVE = 2'h0,
    MODE_MASTER = 2'h1,
    MODE_PIN = 2'h2
  } rms_mode_e;

  typedef enum logic [1:0] {
    ROUTE_STRAIGHT = 2'h0,
    ROUTE_B_BOTH = 2'h1,
    ROUTE_A_BOTH = 2'h2,
    ROUTE_CROSS = 2'h3
  } rms_route_e;

  // Gray path: idle, wait, run, done
  typedef enum logic [1:0] {
    LD_IDLE = 2'h0,
    LD_WAIT = 2'h1,
    LD_RUN = 2'h3,
    LD_DONE = 2'h2
  } rms_load_e;

  localparam int CLK_HZ = 20_000_000;
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int SCL_HALF_NS = 1250;
  // Least time rounds up, longest time rounds down
  localparam int STRAP_CYCLES = (STRAP_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SCL_HALF_CYCLES = (SCL_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int LOAD_SCL_CLOCKS = 288;

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_THRESH = 12'h004;
  localparam logic [11:0] REG_DRIVE = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;

  localparam int CTRL_IRQ_MODE = 0;
  localparam int CTRL_ROUTE_LSB = 1;
  localparam int THR_HORIZ_LSB = 0;
  localparam int THR_VERT_LSB = 8;
  localparam int DRV_DEEMPH_A_LSB = 0;
  localparam int DRV_DEEMPH_B_LSB = 2;
  localparam int DRV_SWING_A_LSB = 4;
  localparam int DRV_SWING_B_LSB = 6;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] THRESH_RESET = 32'h0000_1010;
  localparam logic [31:0] DRIVE_RESET = 32'h0000_0000;

  // Arbitrary upper address bits; the two straps fill the low bits
  localparam logic [4:0] SMB_ADDR_BASE = 5'h0C;

endpackage : rms_pkg

// File: src/rms_level_sense.sv
/*
  One four-level pad: synchroniser, live level and startup-held level.
  Assumes the pad sense code comes from outside the clock domain.
*/
`timescale 1ns/1ps
module rms_level_sense (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [1:0] pad_code,
  input wire logic capture,
  output rms_pkg::rms_level_e live_level,
  output rms_pkg::rms_level_e held_level
);

  logic [1:0] sync_a;
  logic [1:0] sync_b;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sync_a <= 2'h3;
      sync_b <= 2'h3;
    end else begin
      sync_a <= pad_code;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      live_level <= rms_pkg::LVL_FLOAT;
    end else begin
      live_level <= rms_pkg::rms_level_e'(sync_b);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      held_level <= rms_pkg::LVL_FLOAT;
    end else if (capture) begin
      held_level <= live_level;
    end
  end

endmodule : rms_level_sense

// File: src/rms_mode_strap.sv
/*
  Mode selection, strap sampling, EEPROM load handshake and indicator
  pins of a two-channel retimer, with an APB register slave.
  Assumes one 20 MHz clock, synchronous active-low reset, and pads that
  resolve open-drain/bidirectional levels from out and active-low enable.
*/
// Local design decisions: the address map and the APB interface to the registers.
// Overview of operation
// - Lock pin goes high when clock recovery is locked.
// - Lock pin is first sampled as a strap during startup, then driven.
// - Signal-detect pin pulled low while channel A input is valid.
// - Signal-detect pin released when channel A input is lost.
// - In interrupt role, pin low when eye opening falls below threshold.
// - Mode pin: high slave, float EEPROM master, low pin control.
// - Disable pin: high disables B, low enables both, others reserved.
// - First address strap sampled at power-up forms the bus address.
// - In slave mode the second address pin is an address input.
// - In master mode the second address pin drives low when load is done.
// - Active-low load request starts the EEPROM read.
// - Load request may come from the previous device's done output.
// - Bus clock pin is input in slave mode, open-drain output as master.
// - Routing pin: high straight, float B both, 20K A both, low cross.
// - Pin mode: four-level pins set de-emphasis of A and B.
// - Pin mode: four-level pins set launch amplitude of A and B.
// - Pin mode supports only two line rates and limited drive settings.
// - Shared pins change role with the selected mode.
`timescale 1ns/1ps
module rms_mode_strap #(
  parameter int LOAD_CLOCKS = rms_pkg::LOAD_SCL_CLOCKS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] bus_mode_select_pin,
  input wire logic [1:0] sda_deemph_a_code,
  input wire logic [1:0] scl_deemph_b_code,
  input wire logic [1:0] disable_route_code,
  input wire logic [1:0] load_req_swing_a_code,
  input wire logic [1:0] id1_swing_b_code,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic id_strap1_load_done_n_out,
  output logic id_strap1_load_done_n_oe_n,
  input wire logic lock_pin_in,
  output logic lock_pin_out,
  output logic lock_pin_oe_n,
  output logic signal_detect_irq_pin_out,
  output logic signal_detect_irq_pin_oe_n,
  input wire logic chan_a_locked,
  input wire logic chan_b_locked,
  input wire logic chan_a_signal_present,
  input wire logic eye_check_done,
  input wire logic [7:0] eye_horiz,
  input wire logic [7:0] eye_vert,
  output logic [1:0] config_mode,
  output logic [6:0] smbus_addr,
  output logic [1:0] route_sel,
  output logic port_a_output_en,
  output logic port_b_output_en,
  output logic [1:0] chan_a_deemph,
  output logic [1:0] chan_b_deemph,
  output logic [1:0] chan_a_swing,
  output logic [1:0] chan_b_swing,
  output logic pin_rate_limited,
  output logic load_busy
);

  localparam int NPADS = 6;
  localparam int P_MODE = 0;
  localparam int P_SDA = 1;
  localparam int P_SCL = 2;
  localparam int P_DIS = 3;
  localparam int P_REQ = 4;
  localparam int P_ID1 = 5;

  function automatic logic [1:0] lvl_index(input rms_pkg::rms_level_e lvl);
    case (lvl)
      rms_pkg::LVL_LOW: lvl_index = 2'h0;
      rms_pkg::LVL_R20K: lvl_index = 2'h1;
      rms_pkg::LVL_FLOAT: lvl_index = 2'h2;
      default: lvl_index = 2'h3;
    endcase
  endfunction : lvl_index

  logic [NPADS*2-1:0] pad_codes;
  rms_pkg::rms_level_e live [NPADS];
  rms_pkg::rms_level_e held [NPADS];
  logic startup_done;
  logic capture;
  logic [7:0] startup_cnt;

  assign pad_codes = {id1_swing_b_code, load_req_swing_a_code, disable_route_code,
                      scl_deemph_b_code, sda_deemph_a_code, bus_mode_select_pin};

  for (genvar i = 0; i < NPADS; i++) begin : g_pad
    rms_level_sense u_sense (
      .clock(clock),
      .rstn(rstn),
      .pad_code(pad_codes[i*2 +: 2]),
      .capture(capture),
      .live_level(live[i]),
      .held_level(held[i])
    );
  end

  // Straps settle before the levels are frozen
  assign capture = !startup_done && (startup_cnt == 8'(rms_pkg::STRAP_CYCLES));

  always_ff @(posedge clock) begin
    if (!rstn) begin
      startup_cnt <= 8'h00;
      startup_done <= 1'b0;
    end else if (!startup_done) begin
      startup_cnt <= startup_cnt + 8'h01;
      if (capture) begin
        startup_done <= 1'b1;
      end
    end
  end

  // Strap on the lock pin, sampled through two flops
  logic lock_sync_a;
  logic lock_sync_b;
  logic id0_strap;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      lock_sync_a <= 1'b0;
      lock_sync_b <= 1'b0;
    end else begin
      lock_sync_a <= lock_pin_in;
      lock_sync_b <= lock_sync_a;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      id0_strap <= 1'b0;
    end else if (capture) begin
      id0_strap <= lock_sync_b;
    end
  end

  // pin stays an input until straps are taken
  always_ff @(posedge clock) begin
    if (!rstn) begin
      lock_pin_oe_n <= 1'b1;
      lock_pin_out <= 1'b0;
    end else begin
      lock_pin_oe_n <= !startup_done;
      lock_pin_out <= chan_a_locked & chan_b_locked;
    end
  end

  // mode decode; resistor state treated as pin control
  rms_pkg::rms_mode_e mode;
  always_comb begin
    case (held[P_MODE])
      rms_pkg::LVL_HIGH: mode = rms_pkg::MODE_SLAVE;
      rms_pkg::LVL_FLOAT: mode = rms_pkg::MODE_MASTER;
      default: mode = rms_pkg::MODE_PIN;
    endcase
  end

  // Registers
  logic [31:0] ctrl;
  logic [31:0] thresh;
  logic [31:0] drive;
  logic setup_ok;
  logic wr_en;
  logic rd_hit;

  assign pready = 1'b1;
  assign setup_ok = (paddr == rms_pkg::REG_CTRL) || (paddr == rms_pkg::REG_THRESH) ||
                    (paddr == rms_pkg::REG_DRIVE) || (paddr == rms_pkg::REG_STATUS);
  assign pslverr = psel && penable && !setup_ok;
  assign wr_en = psel && penable && pwrite;
  assign rd_hit = psel && !penable && !pwrite;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl <= rms_pkg::CTRL_RESET;
      thresh <= rms_pkg::THRESH_RESET;
      drive <= rms_pkg::DRIVE_RESET;
    end else if (wr_en) begin
      case (paddr)
        rms_pkg::REG_CTRL: ctrl <= {29'h0, pwdata[2:0]};
        rms_pkg::REG_THRESH: thresh <= {16'h0, pwdata[15:0]};
        rms_pkg::REG_DRIVE: drive <= {24'h0, pwdata[7:0]};
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Eye monitor result, kept until the next check
  logic eye_fail;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      eye_fail <= 1'b0;
    end else if (eye_check_done) begin
      eye_fail <= (eye_horiz < thresh[rms_pkg::THR_HORIZ_LSB +: 8]) ||
                  (eye_vert < thresh[rms_pkg::THR_VERT_LSB +: 8]);
    end
  end

  // Open drain: out always low, enable alone decides
  assign signal_detect_irq_pin_out = 1'b0;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      signal_detect_irq_pin_oe_n <= 1'b1;
    end else if (ctrl[rms_pkg::CTRL_IRQ_MODE]) begin
      signal_detect_irq_pin_oe_n <= !eye_fail;
    end else begin
      // pull low on signal, release on loss
      signal_detect_irq_pin_oe_n <= !chan_a_signal_present;
    end
  end

  // Bus clock pin, sampled for stretch detection
  logic scl_sync_a;
  logic scl_sync_b;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      scl_sync_a <= 1'b1;
      scl_sync_b <= 1'b1;
    end else begin
      scl_sync_a <= scl_in;
      scl_sync_b <= scl_sync_a;
    end
  end

  // EEPROM load sequencer
  rms_pkg::rms_load_e ld_state;
  logic [7:0] half_cnt;
  logic [15:0] clk_cnt;
  logic scl_drive_low;
  logic load_req;

  // live level, so a chained done pin can start us
  assign load_req = (live[P_REQ] == rms_pkg::LVL_LOW);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ld_state <= rms_pkg::LD_IDLE;
      half_cnt <= 8'h00;
      clk_cnt <= 16'h0000;
      scl_drive_low <= 1'b0;
    end else begin
      case (ld_state)
        rms_pkg::LD_IDLE: begin
          if (startup_done && mode == rms_pkg::MODE_MASTER) begin
            ld_state <= rms_pkg::LD_WAIT;
          end
        end
        rms_pkg::LD_WAIT: begin
          if (load_req) begin
            ld_state <= rms_pkg::LD_RUN;
            half_cnt <= 8'h00;
            clk_cnt <= 16'h0000;
          end
        end
        rms_pkg::LD_RUN: begin
          // Released clock held low by a slave counts as a stretch
          if (!scl_drive_low && !scl_sync_b) begin
            half_cnt <= 8'h00;
          end else if (half_cnt == 8'(rms_pkg::SCL_HALF_CYCLES - 1)) begin
            half_cnt <= 8'h00;
            scl_drive_low <= !scl_drive_low;
            if (!scl_drive_low) begin
              // Done after the high phase that follows the last low pulse
              if (clk_cnt == 16'(LOAD_CLOCKS)) begin
                ld_state <= rms_pkg::LD_DONE;
              end else begin
                clk_cnt <= clk_cnt + 16'h0001;
              end
            end
          end else begin
            half_cnt <= half_cnt + 8'h01;
          end
        end
        rms_pkg::LD_DONE: begin
          scl_drive_low <= 1'b0;
        end
        default: ld_state <= rms_pkg::LD_IDLE;
      endcase
    end
  end

  assign load_busy = (ld_state == rms_pkg::LD_RUN);

  // open-drain clock only while master loads
  assign scl_out = 1'b0;
  assign scl_oe_n = !(load_busy && scl_drive_low);

  // done flag driven low; input otherwise
  assign id_strap1_load_done_n_out = 1'b0;
  assign id_strap1_load_done_n_oe_n = !(mode == rms_pkg::MODE_MASTER &&
                                        ld_state == rms_pkg::LD_DONE);

  logic id1_bit;
  assign id1_bit = (held[P_ID1] == rms_pkg::LVL_HIGH);
  always_ff @(posedge clock) begin
    if (!rstn) begin
      smbus_addr <= 7'h00;
    end else begin
      smbus_addr <= {rms_pkg::SMB_ADDR_BASE, id1_bit, id0_strap};
    end
  end

  logic reserved_dis;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      config_mode <= 2'h0;
      route_sel <= 2'h0;
      port_a_output_en <= 1'b0;
      port_b_output_en <= 1'b0;
      chan_a_deemph <= 2'h0;
      chan_b_deemph <= 2'h0;
      chan_a_swing <= 2'h0;
      chan_b_swing <= 2'h0;
      pin_rate_limited <= 1'b0;
      reserved_dis <= 1'b0;
    end else if (mode == rms_pkg::MODE_PIN) begin
      config_mode <= mode;
      port_a_output_en <= startup_done;
      port_b_output_en <= startup_done;
      reserved_dis <= 1'b0;
      case (held[P_DIS])
        rms_pkg::LVL_HIGH: route_sel <= rms_pkg::ROUTE_STRAIGHT;
        rms_pkg::LVL_FLOAT: route_sel <= rms_pkg::ROUTE_B_BOTH;
        rms_pkg::LVL_R20K: route_sel <= rms_pkg::ROUTE_A_BOTH;
        default: route_sel <= rms_pkg::ROUTE_CROSS;
      endcase
      chan_a_deemph <= lvl_index(held[P_SDA]);
      chan_b_deemph <= lvl_index(held[P_SCL]);
      chan_a_swing <= lvl_index(held[P_REQ]);
      chan_b_swing <= lvl_index(held[P_ID1]);
      pin_rate_limited <= 1'b1;
    end else begin
      config_mode <= mode;
      pin_rate_limited <= 1'b0;
      route_sel <= ctrl[rms_pkg::CTRL_ROUTE_LSB +: 2];
      chan_a_deemph <= drive[rms_pkg::DRV_DEEMPH_A_LSB +: 2];
      chan_b_deemph <= drive[rms_pkg::DRV_DEEMPH_B_LSB +: 2];
      chan_a_swing <= drive[rms_pkg::DRV_SWING_A_LSB +: 2];
      chan_b_swing <= drive[rms_pkg::DRV_SWING_B_LSB +: 2];
      // disable decode; reserved keeps both on
      port_a_output_en <= startup_done;
      port_b_output_en <= startup_done && (held[P_DIS] != rms_pkg::LVL_HIGH);
      reserved_dis <= (held[P_DIS] == rms_pkg::LVL_FLOAT) ||
                      (held[P_DIS] == rms_pkg::LVL_R20K);
    end
  end

  // Read data registered in setup, valid in access phase
  logic [31:0] status_word;
  assign status_word = {12'h000, smbus_addr, 1'b0, ld_state, reserved_dis, eye_fail,
                        startup_done, chan_b_locked, chan_a_locked,
                        chan_a_signal_present, route_sel, config_mode};

  always_ff @(posedge clock) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_hit) begin
      case (paddr)
        rms_pkg::REG_CTRL: prdata <= ctrl;
        rms_pkg::REG_THRESH: prdata <= thresh;
        rms_pkg::REG_DRIVE: prdata <= drive;
        rms_pkg::REG_STATUS: prdata <= status_word;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : rms_mode_strap
